/* osc_cfg_pkg.sv */
package osc_cfg_pkg;
   // register bus shape
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   // word offsets of the two registers
   localparam logic [3:0] OFF_PLL_MULT = 4'h0;
   localparam logic [3:0] OFF_RC_TRIM = 4'h1;
   // field widths and positions
   localparam int FBDIV_W = 9;
   localparam int FBDIV_LSB = 0;
   localparam int TRIM_W = 6;
   localparam int TRIM_LSB = 0;
   // values after reset
   localparam logic [8:0] FBDIV_RST = 9'h030;
   localparam logic [5:0] TRIM_RST = 6'h00;
   localparam logic [9:0] MULT_RST = 10'h032;
   // bench pacing, in system clock cycles
   localparam int RST_CYCLES = 16;
   localparam int TIMEOUT_CYCLES = 1000;
   // multiplication factor = divisor + offset
   localparam logic [9:0] MULT_OFFSET = 10'h002;
   // trim step in thousandths of a percent
   localparam int TRIM_STEP_MPCT = 375;
   localparam int TRIM_OFS_W = 16;
endpackage

/* rc_trim_offset.sv */
`timescale 1ns/1ps
// turns the signed trim code into a frequency offset in thousandths of a percent
module rc_trim_offset (
   // trim code
   input wire logic [osc_cfg_pkg::TRIM_W-1:0] i_code,
   // signed offset, registered by the caller
   output logic signed [osc_cfg_pkg::TRIM_OFS_W-1:0] o_offset_mpct
);
   import osc_cfg_pkg::*;

   // code is two's complement, so negative codes lower the frequency
   always_comb begin
      o_offset_mpct = TRIM_OFS_W'(signed'(i_code) * TRIM_STEP_MPCT);
   end
endmodule

/* osc_tune_regs.sv */
`timescale 1ns/1ps
module osc_tune_regs (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // register port
   input wire logic [osc_cfg_pkg::ADDR_W-1:0] i_addr,
   input wire logic [osc_cfg_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [osc_cfg_pkg::DATA_W-1:0] o_rdata,
   // to the pll and the fast internal rc oscillator
   output logic [osc_cfg_pkg::FBDIV_W-1:0] o_pll_feedback_divisor,
   output logic [9:0] o_pll_mult_factor,
   output logic [osc_cfg_pkg::TRIM_W-1:0] o_rc_trim_code,
   output logic signed [osc_cfg_pkg::TRIM_OFS_W-1:0] o_rc_offset_mpct
);
   import osc_cfg_pkg::*;

   // true when a strobe is aimed at the given register slot
   function automatic logic reg_hit(input logic strobe, input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] slot);
      return strobe && (addr == slot);
   endfunction

   // pll factor from a divisor field; the extra bit keeps 513 from wrapping
   function automatic logic [9:0] factor_of(input logic [FBDIV_W-1:0] div);
      return {1'b0, div} + MULT_OFFSET;
   endfunction

   // the two implemented slots; everything else on the port is a hole that reads zero
   function automatic logic slot_is_mapped(input logic [ADDR_W-1:0] addr);
      return (addr == OFF_PLL_MULT) || (addr == OFF_RC_TRIM);
   endfunction

   logic [FBDIV_W-1:0] pll_feedback_divisor;
   logic [FBDIV_W-1:0] next_pll_feedback_divisor;
   logic [TRIM_W-1:0] rc_trim_code;
   logic [TRIM_W-1:0] next_rc_trim_code;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] next_rdata;
   logic [9:0] mult;
   logic [9:0] next_mult;
   logic signed [TRIM_OFS_W-1:0] ofs;
   logic signed [TRIM_OFS_W-1:0] ofs_comb;

   rc_trim_offset u_ofs (
      .i_code(next_rc_trim_code),
      .o_offset_mpct(ofs_comb)
   );

   // register writes; only the implemented field bits are taken
   always_comb begin
      next_pll_feedback_divisor = pll_feedback_divisor;
      next_rc_trim_code = rc_trim_code;
      if (reg_hit(i_wr, i_addr, OFF_PLL_MULT)) begin
         next_pll_feedback_divisor = i_wdata[FBDIV_LSB +: FBDIV_W];
      end
      if (reg_hit(i_wr, i_addr, OFF_RC_TRIM)) begin
         next_rc_trim_code = i_wdata[TRIM_LSB +: TRIM_W];
      end
      next_mult = factor_of(next_pll_feedback_divisor);
   end

   // read mux; unmapped addresses and upper bits read zero
   always_comb begin
      next_rdata = '0;
      if (i_rd) begin
         unique case (i_addr)
            OFF_PLL_MULT: next_rdata[FBDIV_LSB +: FBDIV_W] = pll_feedback_divisor;
            OFF_RC_TRIM: next_rdata[TRIM_LSB +: TRIM_W] = rc_trim_code;
            default: next_rdata = '0;
         endcase
      end
   end

   // divisor group; the factor is registered beside it so the pll never sees a half-updated pair
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         pll_feedback_divisor <= FBDIV_RST;
         mult <= MULT_RST;
      end else begin
         pll_feedback_divisor <= next_pll_feedback_divisor;
         mult <= next_mult;
      end
   end

   // trim group; the offset comes from the next code so both outputs change on one edge
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         rc_trim_code <= TRIM_RST;
         ofs <= '0;
      end else begin
         rc_trim_code <= next_rc_trim_code;
         ofs <= ofs_comb;
      end
   end

   // read data; zero outside the answer cycle so a shared read bus stays quiet
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         rdata <= '0;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign o_rdata = rdata;
   assign o_pll_feedback_divisor = pll_feedback_divisor;
   assign o_pll_mult_factor = mult;
   assign o_rc_trim_code = rc_trim_code;
   assign o_rc_offset_mpct = ofs;

   // request shapes on the register port; each check is strobe first, effect one edge later
   sequence s_div_write;
      i_wr && i_addr == OFF_PLL_MULT;
   endsequence
   sequence s_trim_write;
      i_wr && i_addr == OFF_RC_TRIM;
   endsequence
   sequence s_div_read;
      i_rd && i_addr == OFF_PLL_MULT;
   endsequence
   sequence s_trim_read;
      i_rd && i_addr == OFF_RC_TRIM;
   endsequence
   // strobes that hit neither register
   sequence s_dead_write;
      i_wr && !slot_is_mapped(i_addr);
   endsequence
   sequence s_dead_read;
      i_rd && !slot_is_mapped(i_addr);
   endsequence
   // no read strobe at all
   sequence s_no_read;
      !i_rd;
   endsequence

   a_mult_tracks: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_pll_mult_factor == {1'b0, o_pll_feedback_divisor} + 10'h002)
      else $error("pll factor not divisor plus two");
   a_fbdiv_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      s_div_write |=> o_pll_feedback_divisor == $past(i_wdata[8:0]))
      else $error("divisor write lost");
   a_fbdiv_reset: assert property (@(posedge i_clk_sys)
      !i_rst_b |=> o_pll_feedback_divisor == 9'h030 && o_pll_mult_factor == 10'h032)
      else $error("divisor reset value wrong");
   a_trim_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      s_trim_write |=> o_rc_trim_code == $past(i_wdata[5:0]))
      else $error("trim write lost");
   a_trim_reset: assert property (@(posedge i_clk_sys)
      !i_rst_b |=> o_rc_trim_code == 6'h00 && o_rc_offset_mpct == 0)
      else $error("trim reset value wrong");
   a_trim_max: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_rc_trim_code == 6'h1f |-> o_rc_offset_mpct == 16'sd11625)
      else $error("max trim offset wrong");
   a_trim_step: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_rc_trim_code == 6'h01 |-> o_rc_offset_mpct == 16'sd375)
      else $error("single trim step wrong");
   a_read_upper: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      s_div_read |=> o_rdata == {7'h00, $past(o_pll_feedback_divisor)})
      else $error("divisor readback wrong");
   a_read_trim: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      s_trim_read |=> o_rdata == {10'h000, $past(o_rc_trim_code)})
      else $error("trim readback wrong");

   // the factor follows every divisor write, ends of the range included
   a_div_factor_pair: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      s_div_write |=> o_pll_mult_factor == $past(i_wdata[8:0]) + 10'h002)
      else $error("factor not updated with divisor");
   a_factor_range: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_pll_mult_factor >= 10'h002 && o_pll_mult_factor <= 10'h201)
      else $error("pll factor out of range");
   a_div_low_end: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_pll_feedback_divisor == 9'h000 |-> o_pll_mult_factor == 10'h002)
      else $error("lowest factor wrong");
   a_div_high_end: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_pll_feedback_divisor == 9'h1ff |-> o_pll_mult_factor == 10'h201)
      else $error("highest factor wrong");

   // fields hold unless their own slot is written
   a_div_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      !(i_wr && i_addr == OFF_PLL_MULT) |=> $stable(o_pll_feedback_divisor))
      else $error("divisor changed without a write");
   a_trim_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      !(i_wr && i_addr == OFF_RC_TRIM) |=> $stable(o_rc_trim_code) && $stable(o_rc_offset_mpct))
      else $error("trim changed without a write");
   a_dead_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      s_dead_write |=> $stable(o_pll_feedback_divisor) && $stable(o_rc_trim_code))
      else $error("unmapped write disturbed a field");

   // read data stand only in the answer cycle, upper bits always zero
   a_dead_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      s_dead_read |=> o_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      s_no_read |=> o_rdata == 16'h0000)
      else $error("read data outside answer cycle");
   a_rdata_upper: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_rdata[15:9] == 7'h00)
      else $error("unimplemented bits read nonzero");
   a_reset_rdata: assert property (@(posedge i_clk_sys)
      !i_rst_b |=> o_rdata == 16'h0000)
      else $error("read data not cleared by reset");

   // trim code to offset at a few fixed points of the table
   a_trim_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_rc_trim_code == 6'h00 |-> o_rc_offset_mpct == 16'sh0000)
      else $error("zero trim offset wrong");
   a_trim_next_max: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_rc_trim_code == 6'h1e |-> o_rc_offset_mpct == 16'sh2bf2)
      else $error("second highest trim offset wrong");
   a_trim_two: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_rc_trim_code == 6'h02 |-> o_rc_offset_mpct == 16'sh02ee)
      else $error("two step trim offset wrong");
   a_trim_negative: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_rc_trim_code[5] |-> o_rc_offset_mpct < 16'sh0000)
      else $error("negative trim code not below centre");
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import osc_cfg_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rst_b = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [15:0] o_rdata;
   logic [8:0] o_pll_feedback_divisor;
   logic [9:0] o_pll_mult_factor;
   logic [5:0] o_rc_trim_code;
   logic signed [15:0] o_rc_offset_mpct;
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;
   osc_tune_regs dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_pll_feedback_divisor(o_pll_feedback_divisor),
      .o_pll_mult_factor(o_pll_mult_factor), .o_rc_trim_code(o_rc_trim_code), .o_rc_offset_mpct(o_rc_offset_mpct));
   // 100 MHz system clock
   always #5 i_clk_sys = ~i_clk_sys;
   // whole run needs well under 200 cycles, so 1000 means a hang
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == TIMEOUT_CYCLES) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one-cycle write strobe; fields settle one cycle later
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 chk(o_rdata, e);
   endtask
   task automatic test_reset();
      chk({7'h00, o_pll_feedback_divisor}, 16'h0030);
      chk({6'h00, o_pll_mult_factor}, 16'h0032);
      chk({10'h000, o_rc_trim_code}, 16'h0000);
      chk(o_rc_offset_mpct, 16'h0000);
      rd(OFF_PLL_MULT, 16'h0030);
      rd(OFF_RC_TRIM, 16'h0000);
   endtask
   // extreme divisor values, with upper bits set to prove they are dropped
   task automatic test_divisor();
      wr(OFF_PLL_MULT, 16'hfe00);
      chk({6'h00, o_pll_mult_factor}, 16'h0002);
      wr(OFF_PLL_MULT, 16'hffff);
      chk({6'h00, o_pll_mult_factor}, 16'h0201);
      chk({7'h00, o_pll_feedback_divisor}, 16'h01ff);
      rd(OFF_PLL_MULT, 16'h01ff);
   endtask
   task automatic test_trim();
      wr(OFF_RC_TRIM, 16'hffc1);
      chk(o_rc_offset_mpct, 16'h0177);
      chk({10'h000, o_rc_trim_code}, 16'h0001);
      wr(OFF_RC_TRIM, 16'h001e);
      chk(o_rc_offset_mpct, 16'h2bf2);
      wr(OFF_RC_TRIM, 16'h003f);
      chk(o_rc_offset_mpct, 16'hfe89);
      wr(OFF_RC_TRIM, 16'h0020);
      chk(o_rc_offset_mpct, 16'hd120);
      wr(OFF_RC_TRIM, 16'hffdf);
      chk(o_rc_offset_mpct, 16'h2d69);
      rd(OFF_RC_TRIM, 16'h001f);
   endtask
   // an unmapped place reads zero and disturbs nothing
   task automatic test_unmapped();
      wr(4'h2, 16'h1234);
      rd(4'h2, 16'h0000);
      rd(OFF_PLL_MULT, 16'h01ff);
      rd(OFF_RC_TRIM, 16'h001f);
   endtask
   // writes and reads with no idle cycle between strobes
   task automatic test_back_to_back();
      @(posedge i_clk_sys);
      i_addr <= OFF_PLL_MULT;
      i_wdata <= 16'h0055;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_addr <= OFF_RC_TRIM;
      i_wdata <= 16'h0002;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      i_addr <= OFF_PLL_MULT;
      @(posedge i_clk_sys);
      i_addr <= OFF_RC_TRIM;
      #1 chk(o_rdata, 16'h0055);
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 chk(o_rdata, 16'h0002);
      chk({6'h00, o_pll_mult_factor}, 16'h0057);
      chk(o_rc_offset_mpct, 16'h02ee);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (RST_CYCLES) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      #1 test_reset();
      test_divisor();
      test_trim();
      test_unmapped();
      test_back_to_back();
      // second reset in mid-run must restore the power-on values
      @(posedge i_clk_sys);
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      #1 test_reset();
      tally_and_finish();
   end
endmodule
